/* verilog/timer_pkg.sv */
// constants, register map and mode encoding of the timer block
// Operation
// - 8-bit control: enable, polarity, prescale, mode
// - timer runs only while enable bit set
// - disabled output follows polarity bit
// - polarity sets input and/or output sense
// - one-shot: output inverted one cycle after reload
// - continuous: output toggles every reload
// - counter: toggle on reload, count selected edge
// - pwm: match sets level, reload restores it
// - capture: toggle on reload, capture selected edge
// - compare: output toggles every reload
// - gated: output toggles every reload
// - gated: count active level, interrupt inactive edge
// - capture/compare: output toggles every reload
// - capture/compare: first edge starts, later edges capture
// - prescale divides by 2^n, cleared when disabled
package timer_pkg;

  // ---------------------------------------------------------------
  // register map, byte address is four times the index
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [11:0] CTRL_IDX = 12'hf07;
  localparam logic [11:0] COUNT_IDX = 12'hf10;
  localparam logic [11:0] RELOAD_IDX = 12'hf11;
  localparam logic [11:0] CMP_IDX = 12'hf12;
  localparam logic [11:0] CAPT_IDX = 12'hf13;
  localparam logic [11:0] STAT_IDX = 12'hf14;
  localparam logic [11:0] MASK_IDX = 12'hf15;

  // ---------------------------------------------------------------
  // control field layout and reset values
  // ---------------------------------------------------------------
  localparam int EN_BIT = 7;
  localparam int POL_BIT = 6;
  localparam int PRESCALE_SELECT_LSB = 3;
  localparam int MODE_LSB = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] RELOAD_RST = 16'hffff;
  localparam int PRE_W = 7;

  // ---------------------------------------------------------------
  // interrupt status bits
  // ---------------------------------------------------------------
  localparam int ST_W = 3;
  localparam int ST_RELOAD = 0;
  localparam int ST_CAPT = 1;
  localparam int ST_GATE = 2;

  typedef enum logic [2:0] {
    m_one_shot = 3'b000,
    m_continuous = 3'b001,
    m_counter = 3'b010,
    m_pwm = 3'b011,
    m_capture = 3'b100,
    m_compare = 3'b101,
    m_gated = 3'b110,
    m_capt_cmp = 3'b111
  } mode_e;

endpackage

/* verilog/timer_ctrl.sv */
// timer with control register, polarity-dependent modes and apb slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module timer_ctrl #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_in,
  output logic timer_out,
  output logic irq
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [timer_pkg::ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    byte_addr = {2'h0, idx, 2'h0};
  endfunction

  function automatic logic [timer_pkg::PRE_W-1:0] prescale_select_mask(input logic [2:0] sel);
    prescale_select_mask = timer_pkg::PRE_W'((8'h01 << sel) - 8'h01);
  endfunction

  logic [7:0] ctrl_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] reload_reg;
  logic [CNT_W-1:0] cmp_reg;
  logic [CNT_W-1:0] capt_reg;
  logic [timer_pkg::ST_W-1:0] stat_reg;
  logic [timer_pkg::ST_W-1:0] mask_reg;
  logic [timer_pkg::PRE_W-1:0] pre_reg;
  logic in_prev_reg;
  logic started_reg;
  logic done_reg;
  logic pulse_reg;
  logic out_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  logic en;
  logic pol;
  logic [2:0] prescale_select;
  timer_pkg::mode_e mode;
  logic rise;
  logic fall;
  logic sel_edge;
  logic src;
  logic tick;
  logic reload_evt;
  logic match_evt;
  logic capt_evt;
  logic gate_evt;
  logic setup;
  logic wr;
  logic [timer_pkg::ST_W-1:0] evt;

  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------
  assign en = ctrl_reg[timer_pkg::EN_BIT];
  assign pol = ctrl_reg[timer_pkg::POL_BIT];
  assign prescale_select = ctrl_reg[timer_pkg::PRESCALE_SELECT_LSB +: 3];
  assign mode = timer_pkg::mode_e'(ctrl_reg[timer_pkg::MODE_LSB +: 3]);

  // ---------------------------------------------------------------
  // input edges and count source
  // ---------------------------------------------------------------
  assign rise = timer_in & ~in_prev_reg;
  assign fall = ~timer_in & in_prev_reg;
  assign sel_edge = pol ? fall : rise;

  always_comb begin
    unique case (mode)
      timer_pkg::m_counter: src = sel_edge;
      timer_pkg::m_gated: src = timer_in ^ pol;
      timer_pkg::m_capt_cmp: src = started_reg;
      timer_pkg::m_one_shot: src = ~done_reg;
      timer_pkg::m_continuous,
      timer_pkg::m_pwm,
      timer_pkg::m_capture,
      timer_pkg::m_compare: src = 1'b1;
    endcase
  end

  // prescaler: tick when the low prescale_select bits all set
  assign tick = en & src & ((pre_reg & prescale_select_mask(prescale_select)) == prescale_select_mask(prescale_select));
  assign reload_evt = tick & (count_reg >= (mode == timer_pkg::m_compare ? cmp_reg : reload_reg));
  assign match_evt = tick & (mode == timer_pkg::m_pwm) & (count_reg == cmp_reg);
  assign capt_evt = en & sel_edge & ((mode == timer_pkg::m_capture) |
                    ((mode == timer_pkg::m_capt_cmp) & started_reg));
  assign gate_evt = en & (mode == timer_pkg::m_gated) & (pol ? rise : fall);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      in_prev_reg <= 1'b0;
    end else begin
      in_prev_reg <= timer_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !en) begin
      pre_reg <= '0;
    end else if (src) begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !en) begin
      started_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (mode == timer_pkg::m_capt_cmp && sel_edge) begin
        started_reg <= 1'b1;
      end
      if (mode == timer_pkg::m_one_shot && reload_evt) begin
        done_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // counter and capture
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (wr && paddr == byte_addr(timer_pkg::COUNT_IDX)) begin
      count_reg <= pwdata[CNT_W-1:0];
    end else if (reload_evt) begin
      count_reg <= CNT_W'(1);
    end else if (tick) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      capt_reg <= '0;
    end else if (capt_evt) begin
      capt_reg <= count_reg;
    end
  end

  // ---------------------------------------------------------------
  // timer output
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= reload_evt & (mode == timer_pkg::m_one_shot);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
    end else if (!en) begin
      out_reg <= pol;
    end else if (mode == timer_pkg::m_pwm) begin
      if (reload_evt) begin
        out_reg <= pol;
      end else if (match_evt) begin
        out_reg <= ~pol;
      end
    end else if (reload_evt || pulse_reg) begin
      // one-shot flips back after one cycle, others just toggle
      out_reg <= ~out_reg;
    end
  end

  assign timer_out = out_reg;

  // ---------------------------------------------------------------
  // apb slave, zero wait states, read data latched in setup
  // ---------------------------------------------------------------
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      unique case (paddr)
        byte_addr(timer_pkg::CTRL_IDX): prdata_reg <= {24'h0, ctrl_reg};
        byte_addr(timer_pkg::COUNT_IDX): prdata_reg <= 32'(count_reg);
        byte_addr(timer_pkg::RELOAD_IDX): prdata_reg <= 32'(reload_reg);
        byte_addr(timer_pkg::CMP_IDX): prdata_reg <= 32'(cmp_reg);
        byte_addr(timer_pkg::CAPT_IDX): prdata_reg <= 32'(capt_reg);
        byte_addr(timer_pkg::STAT_IDX): prdata_reg <= 32'(stat_reg);
        byte_addr(timer_pkg::MASK_IDX): prdata_reg <= 32'(mask_reg);
        default: pslverr_reg <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg <= timer_pkg::CTRL_RST;
      reload_reg <= timer_pkg::RELOAD_RST[CNT_W-1:0];
      cmp_reg <= '0;
      mask_reg <= '0;
    end else if (wr) begin
      unique case (paddr)
        byte_addr(timer_pkg::CTRL_IDX): ctrl_reg <= pwdata[7:0];
        byte_addr(timer_pkg::RELOAD_IDX): reload_reg <= pwdata[CNT_W-1:0];
        byte_addr(timer_pkg::CMP_IDX): cmp_reg <= pwdata[CNT_W-1:0];
        byte_addr(timer_pkg::MASK_IDX): mask_reg <= pwdata[timer_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ---------------------------------------------------------------
  always_comb begin
    evt = '0;
    evt[timer_pkg::ST_RELOAD] = reload_evt;
    evt[timer_pkg::ST_CAPT] = capt_evt;
    evt[timer_pkg::ST_GATE] = gate_evt;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat_reg <= '0;
    end else if (wr && paddr == byte_addr(timer_pkg::STAT_IDX)) begin
      stat_reg <= (stat_reg & ~pwdata[timer_pkg::ST_W-1:0]) | evt;
    end else begin
      stat_reg <= stat_reg | evt;
    end
  end

  assign irq = |(stat_reg & mask_reg);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_disabled_out_pol: assert property (!en |=> timer_out == $past(pol))
    else $error("disabled output differs from polarity");
  a_stopped_no_count: assert property (
      !en && !(wr && paddr == byte_addr(timer_pkg::COUNT_IDX)) |=> $stable(count_reg))
    else $error("count moved while disabled");
  a_oneshot_pulse_len: assert property (
      reload_evt && en && mode == timer_pkg::m_one_shot
      |=> (timer_out != $past(timer_out)) ##1 (timer_out == $past(timer_out, 2) || !en))
    else $error("one-shot pulse not one cycle");
  a_cont_reload_toggle: assert property (
      reload_evt && mode == timer_pkg::m_continuous |=> timer_out != $past(timer_out))
    else $error("continuous output did not toggle");
  a_reload_out_toggle: assert property (
      reload_evt && mode != timer_pkg::m_pwm && mode != timer_pkg::m_one_shot
      |=> timer_out != $past(timer_out))
    else $error("output did not toggle on reload");
  a_pwm_match_level: assert property (
      match_evt && !reload_evt |=> timer_out == !$past(pol))
    else $error("pwm match level wrong");
  a_counter_edge_only: assert property (
      en && mode == timer_pkg::m_counter && !sel_edge && !wr |=> $stable(count_reg))
    else $error("counter advanced without edge");
  a_capture_value: assert property (capt_evt |=> capt_reg == $past(count_reg))
    else $error("capture value wrong");
  a_gated_hold: assert property (
      en && mode == timer_pkg::m_gated && (timer_in == pol) && !wr |=> $stable(count_reg))
    else $error("gated counted while gate inactive");
  a_gate_irq_set: assert property (gate_evt |=> stat_reg[timer_pkg::ST_GATE])
    else $error("gate end not flagged");
  a_prescale_clear: assert property (!en |=> pre_reg == '0)
    else $error("prescaler not cleared");
  a_ctrl_write_next: assert property (
      wr && paddr == byte_addr(timer_pkg::CTRL_IDX) |=> ctrl_reg == $past(pwdata[7:0]))
    else $error("control write not applied");

endmodule

/* dv/timer_pin_model.sv */
// pin-side model: drives the timer input, timer output port is connected but never read
`timescale 1ns/1ps
module timer_pin_model #(
  parameter int HOLD = 2
) (
  input wire logic sys_clk,
  output logic timer_in,
  input wire logic timer_out
);
  initial begin
    timer_in = 1'b0;
  end

  // ---------------------------------------------------------------
  // input stimulus
  // ---------------------------------------------------------------
  task automatic set_idle(input logic v);
    @(posedge sys_clk);
    timer_in <= v;
  endtask

  // each level held HOLD cycles so every edge is seen
  task automatic pulse(input logic idle, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      timer_in <= ~idle;
      repeat (HOLD) @(posedge sys_clk);
      timer_in <= idle;
      repeat (HOLD) @(posedge sys_clk);
    end
  endtask
endmodule

/* dv/timer_control_polarity_modes_bench.sv */
// self-checking bench for the timer control block
`timescale 1ns/1ps
module timer_control_polarity_modes_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_in;
  logic timer_out;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;

  always #2.5 sys_clk = ~sys_clk;

  timer_ctrl timer_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_in(timer_in),
    .timer_out(timer_out), .irq(irq));

  timer_pin_model timer_pin_model_i (.sys_clk(sys_clk), .timer_in(timer_in),
    .timer_out(timer_out));

  // ---------------------------------------------------------------
  // reporting and checks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // apb master
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  task automatic wait_out(input logic v);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (timer_out !== v && k < 40);
    chk({31'h0, timer_out}, {31'h0, v});
  endtask

  function automatic logic [31:0] ctl(input int en, input int pol,
    input int prescale_select, input timer_pkg::mode_e m);
    return {24'h00_0000, 1'(en), 1'(pol), 3'(prescale_select), m};
  endfunction

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk({31'h0, timer_out}, 32'h0);
    rd(timer_pkg::CTRL_IDX, 32'h00);
    rd(timer_pkg::RELOAD_IDX, 32'hffff);
    wr(timer_pkg::CTRL_IDX, 32'hff);
    rd(timer_pkg::CTRL_IDX, 32'hff);
    wr(timer_pkg::CTRL_IDX, ctl(0, 0, 0, timer_pkg::m_continuous));
    wr(timer_pkg::COUNT_IDX, 32'h0);
    repeat (10) @(posedge sys_clk);
    rd(timer_pkg::COUNT_IDX, 32'h0);
    wr(timer_pkg::RELOAD_IDX, 32'h2);
    wr(timer_pkg::CTRL_IDX, ctl(1, 0, 0, timer_pkg::m_continuous));
    wait_out(1'b1);
    wait_out(1'b0);
    chk({31'h0, irq}, 32'h0);
    rd(timer_pkg::STAT_IDX, 32'h1);
    wr(timer_pkg::MASK_IDX, 32'h1);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    wr(timer_pkg::CTRL_IDX, ctl(0, 1, 0, timer_pkg::m_pwm));
    wr(timer_pkg::STAT_IDX, 32'h7);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, timer_out}, 32'h1);
    wr(timer_pkg::COUNT_IDX, 32'h0);
    wr(timer_pkg::CMP_IDX, 32'h4);
    wr(timer_pkg::RELOAD_IDX, 32'h8);
    wr(timer_pkg::CTRL_IDX, ctl(1, 1, 0, timer_pkg::m_pwm));
    wait_out(1'b0);
    wait_out(1'b1);
    wr(timer_pkg::CTRL_IDX, 32'h0);
    wr(timer_pkg::COUNT_IDX, 32'h0);
    wr(timer_pkg::RELOAD_IDX, 32'h3);
    wr(timer_pkg::CTRL_IDX, ctl(1, 0, 0, timer_pkg::m_one_shot));
    wait_out(1'b1);
    @(negedge sys_clk);
    chk({31'h0, timer_out}, 32'h0);
    repeat (10) @(negedge sys_clk);
    chk({31'h0, timer_out}, 32'h0);
    wr(timer_pkg::CTRL_IDX, 32'h0);
    wr(timer_pkg::RELOAD_IDX, 32'hffff);
    wr(timer_pkg::COUNT_IDX, 32'h0);
    timer_pin_model_i.set_idle(1'b1);
    wr(timer_pkg::CTRL_IDX, ctl(1, 1, 0, timer_pkg::m_counter));
    timer_pin_model_i.pulse(1'b1, 5);
    wr(timer_pkg::CTRL_IDX, 32'h0);
    rd(timer_pkg::COUNT_IDX, 32'h5);
    wr(timer_pkg::COUNT_IDX, 32'h0);
    wr(timer_pkg::CTRL_IDX, ctl(1, 1, 1, timer_pkg::m_counter));
    timer_pin_model_i.pulse(1'b1, 6);
    wr(timer_pkg::CTRL_IDX, 32'h0);
    rd(timer_pkg::COUNT_IDX, 32'h3);
    timer_pin_model_i.set_idle(1'b0);
    wr(timer_pkg::STAT_IDX, 32'h7);
    wr(timer_pkg::CTRL_IDX, ctl(1, 0, 0, timer_pkg::m_capture));
    timer_pin_model_i.pulse(1'b0, 1);
    wr(timer_pkg::CTRL_IDX, 32'h0);
    rd(timer_pkg::STAT_IDX, 32'h2);
    rd(timer_pkg::CAPT_IDX, 32'h4);
    wr(timer_pkg::COUNT_IDX, 32'h0);
    wr(timer_pkg::STAT_IDX, 32'h7);
    wr(timer_pkg::RELOAD_IDX, 32'h1);
    wr(timer_pkg::CTRL_IDX, ctl(1, 0, 0, timer_pkg::m_gated));
    repeat (8) @(posedge sys_clk);
    rd(timer_pkg::COUNT_IDX, 32'h0);
    timer_pin_model_i.pulse(1'b0, 1);
    wait_out(1'b1);
    wr(timer_pkg::CTRL_IDX, 32'h0);
    rd(timer_pkg::STAT_IDX, 32'h5);
    rd(timer_pkg::COUNT_IDX, 32'h1);
    wr(timer_pkg::RELOAD_IDX, 32'hffff);
    wr(timer_pkg::COUNT_IDX, 32'h5);
    wr(timer_pkg::STAT_IDX, 32'h7);
    wr(timer_pkg::CTRL_IDX, ctl(1, 0, 0, timer_pkg::m_capt_cmp));
    repeat (8) @(posedge sys_clk);
    rd(timer_pkg::COUNT_IDX, 32'h5);
    timer_pin_model_i.pulse(1'b0, 1);
    rd(timer_pkg::STAT_IDX, 32'h0);
    timer_pin_model_i.pulse(1'b0, 1);
    rd(timer_pkg::STAT_IDX, 32'h2);
    wr(timer_pkg::RELOAD_IDX, 32'h3);
    wait_out(1'b1);
    wr(timer_pkg::CTRL_IDX, 32'h0);
    wr(timer_pkg::RELOAD_IDX, 32'hffff);
    wr(timer_pkg::COUNT_IDX, 32'h0);
    wr(timer_pkg::CTRL_IDX, ctl(1, 0, 0, timer_pkg::m_compare));
    wait_out(1'b1);
    wait_out(1'b0);
    apb(1'b0, 12'hf16, 32'h0);
    chk(rdat, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    end_sim();
  end
endmodule
